/* File: hw/sac_top.sv */
// Converter control block with temperature sense, classic Wishbone slave
// Function
// [RL1] Temperature circuit powered only while its enable bit is set.
// [RL2] Range bit one selects high range, zero selects low range.
// [RL3] Software waits 200 us after routing to sensor before converting.
// [RL4] Software spaces sensor conversions at least 200 us apart.
// [RL5] Sensor output reaches the converter only through its own channel.
// [RL6] Ten-bit successive approximation result stored in high/low pair.
// [RL7] Channel select picks one of eleven inputs for sample-and-hold.
// [RL8] Software waits an acquisition delay after a channel change.
// [RL9] Positive reference per select field; negative reference always ground.
// [RL10] Clock select gives system /2../64 or the dedicated RC clock.
// [RL11] One conversion lasts 11.5 bit periods.
// [RL12] System-derived bit clock tracks system clock; RC is independent.
// [RL13] Above 1 MHz, software picks RC only for conversions in sleep.
// [RL14] Conversion continues in sleep only with RC clock selected.
// [RL15] Done flag set at end of every conversion regardless of enable.
// [RL16] Software clears the done flag; hardware never clears it.
// [RL17] Flag forwarded as request only while its enable bit is set.
// [RL18] Enabled completion during sleep wakes the device.
// [RL19] Vector after wake only if global and peripheral enables set.
// [RL20] Go bit starts; at end go clears, flag sets, result updates.
// [RL21] Go cleared mid-way: partial result, rest filled with last bit.
// [RL22] Sleep with non-RC clock aborts conversion, converter off, on bit kept.
// [RL23] Request equals flag AND enable, held until flag cleared.
// [RL24] Reset clears go, flag and all control fields, abandoning conversion.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module sac_top (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             rc_tick_i,
  input  wire logic             sleep_i,
  input  wire logic             comp_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [5:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic      [9:0]       dac_trial_o,
  output logic                  sample_o,
  output logic      [4:0]       channel_select_o,
  output logic      [1:0]       positive_ref_select_o,
  output logic                  converter_powered_o,
  output logic                  temp_sense_enable_o,
  output logic                  temp_range_select_o,
  output logic                  irq_o,
  output logic                  wake_o,
  output logic                  vector_o
);
  import sac_pkg::*;

  // ---------------------------------------------------------------
  // Registers and bus decode
  // ---------------------------------------------------------------
  logic [7:0] ctrl0_r, ctrl1_r, reft_r, pen_r, irqc_r;
  logic       flag_r, ack_r, go_clr, done_ev;
  logic [9:0] res_r, sar_r;
  logic [3:0] bit_r;
  logic [4:0] half_r;
  logic [5:0] div_r;
  logic       tick;
  sac_state_t st_r;

  wire acc = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr  = acc & wb_we_i & wb_sel_i[0];
  wire rc_sel = (ctrl1_r[B_CS +: 2] == CS_RC);
  wire busy = (st_r != SAC_IDLE);
  wire halt = sleep_i & ~rc_sel;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    return a == o;
  endfunction

  assign wb_ack_o = ack_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else ack_r <= acc;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_dat_o <= 32'h0000_0000;
    else if (acc) begin
      unique case (1'b1)
        hit(wb_adr_i, {2'b00, OFF_CTRL0}): wb_dat_o <= {24'h00_0000, ctrl0_r};
        hit(wb_adr_i, {2'b00, OFF_CTRL1}): wb_dat_o <= {24'h00_0000, ctrl1_r};
        hit(wb_adr_i, {2'b00, OFF_RESH}):  wb_dat_o <= {30'h0, res_r[9:8]};
        hit(wb_adr_i, {2'b00, OFF_RESL}):  wb_dat_o <= {24'h00_0000, res_r[7:0]};
        hit(wb_adr_i, OFF_REFT): wb_dat_o <= {24'h00_0000, reft_r[7],
                                  1'b1, reft_r[5:0]};
        hit(wb_adr_i, OFF_FLAG): wb_dat_o <= {31'h0, flag_r};
        hit(wb_adr_i, OFF_PEN):  wb_dat_o <= {24'h00_0000, pen_r};
        hit(wb_adr_i, OFF_IRQC): wb_dat_o <= {24'h00_0000, irqc_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control 0: go bit set by software, cleared by hardware at end
  assign go_clr = done_ev | halt;
  always_ff @(posedge clk_i) begin
    if (rst_i) ctrl0_r <= RST_BYTE; // see [RL24]
    else begin
      if (wr && hit(wb_adr_i, {2'b00, OFF_CTRL0}))
        ctrl0_r <= {1'b0, wb_dat_i[6:0]};
      if (go_clr)
        ctrl0_r[B_GO] <= 1'b0; // see [RL20] see [RL22]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_r <= RST_BYTE;
      reft_r  <= RST_BYTE;
      pen_r   <= RST_BYTE;
      irqc_r  <= RST_BYTE;
    end else if (wr) begin
      if (hit(wb_adr_i, {2'b00, OFF_CTRL1}))
        ctrl1_r <= {1'b0, wb_dat_i[6:4], 2'b00, wb_dat_i[1:0]};
      if (hit(wb_adr_i, OFF_REFT)) reft_r <= wb_dat_i[7:0];
      if (hit(wb_adr_i, OFF_PEN))  pen_r  <= wb_dat_i[7:0];
      if (hit(wb_adr_i, OFF_IRQC)) irqc_r <= wb_dat_i[7:0];
    end
  end

  // Flag: set wins over a same-cycle software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) flag_r <= 1'b0;
    else if (done_ev) flag_r <= 1'b1; // see [RL15]
    else if (wr && hit(wb_adr_i, OFF_FLAG)) flag_r <= wb_dat_i[0]; // see [RL16]
  end

  // ---------------------------------------------------------------
  // Bit clock: half-period tick from divider or RC tick
  // ---------------------------------------------------------------
  // Divider runs on the system clock, so it follows any change in it
  wire [2:0] cs = ctrl1_r[B_CS +: 3];
  logic [5:0] lim;
  always_comb begin
    unique case (cs)
      3'b000: lim = 6'd0;
      3'b100: lim = 6'd1;
      3'b001: lim = 6'd3;
      3'b101: lim = 6'd7;
      3'b010: lim = 6'd15;
      3'b110: lim = 6'd31;
      default: lim = 6'd0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy) div_r <= 6'd0;
    else if (div_r >= lim) div_r <= 6'd0; // see [RL10] see [RL12]
    else div_r <= div_r + 6'd1;
  end
  assign tick = rc_sel ? rc_tick_i : (div_r >= lim); // see [RL10]

  // ---------------------------------------------------------------
  // Successive approximation sequencer
  // ---------------------------------------------------------------
  wire go = ctrl0_r[B_GO] & ctrl0_r[B_ON];
  wire abort = busy & ~ctrl0_r[B_GO];
  assign done_ev = (st_r == SAC_BITS) && tick && (half_r == HALF_TOTAL - 5'd1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= SAC_IDLE; // see [RL24]
      half_r <= 5'd0;
      bit_r <= 4'd9;
      sar_r <= 10'h000;
      res_r <= 10'h000;
    end else if (halt && busy) begin
      st_r <= SAC_IDLE; // see [RL22]
    end else if (abort) begin
      st_r <= SAC_IDLE;
      // Unconverted bits copy the last decided bit
      for (int i = 0; i < RES_W; i++)
        res_r[i] <= (i > int'(bit_r)) ? sar_r[i] :
                    (bit_r == 4'd9 ? 1'b0 : sar_r[bit_r + 4'd1]); // see [RL21]
    end else begin
      unique case (st_r)
        SAC_IDLE: if (go) begin
          st_r <= SAC_SETTLE;
          half_r <= 5'd0;
          bit_r <= 4'd9;
          sar_r <= 10'h200;
        end
        SAC_SETTLE: if (tick) begin
          st_r <= SAC_BITS;
          half_r <= 5'd1;
        end
        SAC_BITS: if (tick) begin
          half_r <= half_r + 5'd1; // see [RL11]
          if (half_r[0] && half_r < 5'd21) begin
            sar_r[bit_r] <= comp_i; // see [RL6]
            if (bit_r != 4'd0) begin
              sar_r[bit_r - 4'd1] <= 1'b1;
              bit_r <= bit_r - 4'd1;
            end
          end
          if (done_ev) begin
            st_r <= SAC_IDLE;
            res_r <= sar_r; // see [RL20]
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dac_trial_o = sar_r;
  assign sample_o = (st_r == SAC_IDLE) & ctrl0_r[B_ON] & ~halt;
  assign channel_select_o = ctrl0_r[B_CHS +: 5]; // see [RL7] see [RL5]
  assign positive_ref_select_o = ctrl1_r[B_PREF +: 2]; // see [RL9]
  assign converter_powered_o = ctrl0_r[B_ON] & ~halt; // see [RL14] see [RL22]
  assign temp_sense_enable_o = reft_r[B_TEMP_SENSE_ENABLE]; // see [RL1]
  assign temp_range_select_o = reft_r[B_TEMP_RANGE_SELECT]; // see [RL2]
  assign irq_o = flag_r & pen_r[0]; // see [RL17] see [RL23]
  assign wake_o = irq_o & sleep_i; // see [RL18]
  assign vector_o = irq_o & irqc_r[B_GIE] & irqc_r[B_PERIPHERAL_IRQ_ENABLE]; // see [RL19]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i) done_ev |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) // see [RL15]
    else $error("flag not set");
  property p_go_clr;
    @(posedge clk_i) disable iff (rst_i) done_ev |=> !ctrl0_r[B_GO];
  endproperty
  a_go_clr: assert property (p_go_clr) // see [RL20]
    else $error("go not cleared");
  // Request must hold while neither flag nor enable is rewritten
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      (irq_o && !(wr && (hit(wb_adr_i, OFF_FLAG) ||
                         hit(wb_adr_i, OFF_PEN)))) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) // see [RL23]
    else $error("irq dropped");
  property p_ts;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit(wb_adr_i, OFF_REFT)) |=>
        (temp_sense_enable_o == $past(wb_dat_i[B_TEMP_SENSE_ENABLE]));
  endproperty
  a_ts: assert property (p_ts) // see [RL1]
    else $error("sense power wrong");
  property p_range;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit(wb_adr_i, OFF_REFT)) |=>
        (temp_range_select_o == $past(wb_dat_i[B_TEMP_RANGE_SELECT]));
  endproperty
  a_range: assert property (p_range) // see [RL2]
    else $error("range wrong");
  property p_halt;
    @(posedge clk_i) disable iff (rst_i) (busy && halt) |=> !busy;
  endproperty
  a_halt: assert property (p_halt) // see [RL22]
    else $error("sleep abort");
  property p_keep;
    @(posedge clk_i) disable iff (rst_i)
      (flag_r && !(wr && hit(wb_adr_i, OFF_FLAG))) |=> flag_r;
  endproperty
  a_keep: assert property (p_keep) // see [RL16]
    else $error("flag self clear");
  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
      (done_ev && sleep_i && pen_r[0]) |=> (wake_o || !sleep_i);
  endproperty
  a_wake: assert property (p_wake) // see [RL18]
    else $error("no wake");
  property p_abort;
    @(posedge clk_i) disable iff (rst_i) (abort && !halt) |=> !busy;
  endproperty
  a_abort: assert property (p_abort) // see [RL21]
    else $error("abort");
  property p_start;
    @(posedge clk_i) disable iff (rst_i)
      (st_r == SAC_IDLE && go && !halt) |=> (st_r == SAC_SETTLE);
  endproperty
  a_start: assert property (p_start) // see [RL20]
    else $error("no start");
  property p_result;
    @(posedge clk_i) disable iff (rst_i)
      (done_ev && !abort && !halt) |=> (res_r == $past(sar_r));
  endproperty
  a_result: assert property (p_result) // see [RL6]
    else $error("bad result");
  // A divided bit clock slower than /2 never ticks on two edges in a row
  property p_div;
    @(posedge clk_i) disable iff (rst_i)
      (busy && !rc_sel && lim != 6'd0 && tick) |=> !tick;
  endproperty
  a_div: assert property (p_div) // see [RL10]
    else $error("divider too fast");
  property p_rst;
    @(posedge clk_i) $fell(rst_i) |->
      (!busy && !flag_r && !ctrl0_r[B_GO]);
  endproperty
  a_rst: assert property (p_rst) // see [RL24]
    else $error("reset left state");
  c_done: cover property (@(posedge clk_i) done_ev);
  c_abort: cover property (@(posedge clk_i) abort && !halt);
  c_wake: cover property (@(posedge clk_i) wake_o);
  c_rc_sleep: cover property (@(posedge clk_i) done_ev && sleep_i && rc_sel);
  c_sleep_abort: cover property (@(posedge clk_i) busy && halt);
endmodule // sac_top
`default_nettype wire

/* File: pkg/sac_pkg.sv */
// Package: register map, field layout and timing constants of the converter
`default_nettype none
package sac_pkg;
  localparam int unsigned RES_W = 10;
  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CTRL1 = 4'h4;
  localparam logic [3:0] OFF_RESH  = 4'h8;
  localparam logic [3:0] OFF_RESL  = 4'hC;
  localparam logic [5:0] OFF_REFT  = 6'h10;
  localparam logic [5:0] OFF_FLAG  = 6'h14;
  localparam logic [5:0] OFF_PEN   = 6'h18;
  localparam logic [5:0] OFF_IRQC  = 6'h1C;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  // Control 0 fields
  localparam int unsigned B_ON = 0;
  localparam int unsigned B_GO = 1;
  localparam int unsigned B_CHS = 2;
  // Control 1 fields
  localparam int unsigned B_PREF = 0;
  localparam int unsigned B_CS = 4;
  // Reference/temperature control fields
  localparam int unsigned B_TEMP_RANGE_SELECT = 4;
  localparam int unsigned B_TEMP_SENSE_ENABLE = 5;
  localparam int unsigned B_FRDY = 6;
  localparam int unsigned B_FEN = 7;
  // Interrupt control fields
  localparam int unsigned B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int unsigned B_GIE = 7;
  // Channel codes
  localparam logic [4:0] CH_LAST_PIN = 5'h07;
  localparam logic [4:0] CH_TEMP = 5'h1D;
  localparam logic [4:0] CH_DAC  = 5'h1E;
  localparam logic [4:0] CH_FREF = 5'h1F;
  // Conversion: 1 settle half + 10 bits + 2 write halves = 23 half periods
  localparam logic [4:0] HALF_TOTAL = 5'd23;
  localparam logic [1:0] CS_RC = 2'b11;
  typedef enum logic [1:0] {SAC_IDLE, SAC_SETTLE, SAC_BITS} sac_state_t;
endpackage
`default_nettype wire

/* File: verification/sac_analog_model.sv */
// Analog side model: comparator against a set level and RC tick source
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
  input  wire logic       clk_i,
  input  wire logic [9:0] trial_i,
  input  wire logic [9:0] level_i,
  output logic            comp_o,
  output logic            tick_o
);
  logic [1:0] div_r = 2'h0;
  // Keep the trial bit while the input sits at or above the trial level
  assign comp_o = (level_i >= trial_i);
  // RC tick runs free, unrelated to any conversion, as the oscillator does
  assign tick_o = (div_r == 2'h2);
  always_ff @(posedge clk_i) begin
    div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
  end
endmodule // sac_analog_model
`default_nettype wire

/* File: verification/sac_top_tb.sv */
// Testbench: registers, conversions on every clock select, irq and aborts
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb;
  import sac_pkg::*;
  localparam logic [5:0] A0 = 6'(OFF_CTRL0);
  localparam logic [5:0] A1 = 6'(OFF_CTRL1);
  localparam logic [5:0] AH = 6'(OFF_RESH);
  localparam logic [5:0] AL = 6'(OFF_RESL);
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sleep_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  logic        lane0 = 1'b1;
  logic [9:0]  level = 10'h000;
  logic [31:0] rdat, q;
  logic [9:0]  trial;
  logic [4:0]  channel_select;
  logic [1:0]  prs;
  logic        tick, comp, ack, smp, pwr, tse, tsr, irq, wake, vec;
  int          mismatches = 0;
  int          checks_done = 0;

  sac_top i_sac_top (.clk_i(clk_i), .rst_i(rst_i), .rc_tick_i(tick),
    .sleep_i(sleep_i), .comp_i(comp), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dac_trial_o(trial), .sample_o(smp),
    .channel_select_o(channel_select), .positive_ref_select_o(prs),
    .converter_powered_o(pwr), .temp_sense_enable_o(tse),
    .temp_range_select_o(tsr), .irq_o(irq), .wake_o(wake), .vector_o(vec));
  sac_analog_model i_sac_analog_model (.clk_i(clk_i), .trial_i(trial),
    .level_i(level), .comp_o(comp), .tick_o(tick));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // One classic cycle; the answer is taken at the edge that sees ack
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {3'b000, lane0};
    wdat <= {24'h00_0000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n == 20) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic rd(input logic [5:0] a, input string nm, input logic [31:0] e);
    bus(a, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask

  initial begin
    int n;
    int k;
    logic [2:0] cs;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A0, "ctrl0 rst", 32'h0000_0000);
    rd(A1, "ctrl1 rst", 32'h0000_0000);
    rd(OFF_REFT, "reft rst", 32'h0000_0040);
    rd(OFF_FLAG, "flag rst", 32'h0000_0000);
    chk("idle rst", 32'h0000_0000, 32'({smp, pwr}));
    chk("temp off", 32'h0000_0000, 32'(tse));
    // A write without byte lane 0 must leave the register alone
    lane0 = 1'b0;
    bus(A1, 1'b1, 8'h33);
    lane0 = 1'b1;
    rd(A1, "lane refused", 32'h0000_0000);
    bus(OFF_REFT, 1'b1, 8'h30);
    chk("temp high", 32'h0000_0003, 32'({tse, tsr}));
    bus(OFF_REFT, 1'b1, 8'h20);
    chk("temp low", 32'h0000_0002, 32'({tse, tsr}));
    rd(OFF_REFT, "reft", 32'h0000_0060);
    bus(6'h3C, 1'b1, 8'hFF);
    rd(6'h3C, "unmapped", 32'h0000_0000);
    // ------------------------------------------------------------
    // Full conversions over every clock select
    // ------------------------------------------------------------
    // RC selections run asleep, as a fast system clock calls for
    for (k = 0; k < 8; k++) begin
      cs = 3'(k);
      level <= {cs, 7'h55};
      bus(A1, 1'b1, {1'b0, cs, 2'b00, 2'(k)});
      chk("pos ref", 32'(k % 4), 32'(prs));
      bus(OFF_PEN, 1'b1, {7'h00, k == 7});
      bus(A0, 1'b1, {1'b0, CH_TEMP, 2'b01});
      chk("channel", 32'(CH_TEMP), 32'(channel_select));
      chk("sample", 32'h0000_0001, 32'(smp));
      repeat (2000) @(posedge clk_i);
      sleep_i <= (cs[1:0] == CS_RC);
      bus(A0, 1'b1, {1'b0, CH_TEMP, 2'b11});
      for (n = 0; n < 400; n++) begin
        bus(A0, 1'b0, 8'h00);
        if (q[B_GO] === 1'b0) break;
      end
      chk("go done", 32'h0000_0001, 32'(n < 400));
      if (n == 400) conclude();
      chk("irq wake", (k == 7) ? 32'h0000_0003 : 32'h0000_0000,
          32'({irq, wake}));
      sleep_i <= 1'b0;
      rd(OFF_FLAG, "flag", 32'h0000_0001);
      rd(AH, "res hi", 32'(level[9:8]));
      rd(AL, "res lo", 32'(level[7:0]));
      if (k < 7) bus(OFF_FLAG, 1'b1, 8'h00);
    end
    bus(OFF_PEN, 1'b1, 8'h00);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    bus(OFF_PEN, 1'b1, 8'h01);
    chk("irq", 32'h0000_0002, 32'({irq, vec}));
    bus(OFF_IRQC, 1'b1, 8'h40);
    chk("vec pe only", 32'h0000_0000, 32'(vec));
    bus(OFF_IRQC, 1'b1, 8'hC0);
    sleep_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("wake vec", 32'h0000_0003, 32'({vec, wake}));
    chk("rc sleep", 32'h0000_0001, 32'(pwr));
    bus(OFF_FLAG, 1'b1, 8'h00);
    chk("irq clr", 32'h0000_0000, 32'({irq, wake}));
    sleep_i <= 1'b0;
    // Stop mid-way with every decided bit one: fill must give all ones
    level <= 10'h3FF;
    bus(A1, 1'b1, 8'h60);
    repeat (2000) @(posedge clk_i);
    bus(A0, 1'b1, {1'b0, CH_TEMP, 2'b11});
    repeat (300) @(posedge clk_i);
    bus(A0, 1'b1, {1'b0, CH_TEMP, 2'b01});
    repeat (4) @(posedge clk_i);
    rd(AH, "part hi", 32'h0000_0003);
    rd(AL, "part lo", 32'h0000_00FF);
    repeat (2000) @(posedge clk_i);
    bus(A0, 1'b1, {1'b0, CH_TEMP, 2'b11});
    repeat (100) @(posedge clk_i);
    sleep_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("sleep off", 32'h0000_0000, 32'(pwr));
    bus(A0, 1'b0, 8'h00);
    chk("on kept", 32'h0000_0001, 32'({q[B_GO], q[B_ON]}));
    sleep_i <= 1'b0;
    repeat (2000) @(posedge clk_i);
    bus(A0, 1'b1, {1'b0, CH_TEMP, 2'b11});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A0, "ctrl0 rerst", 32'h0000_0000);
    rd(OFF_FLAG, "flag rerst", 32'h0000_0000);
    chk("trial rerst", 32'h0000_0000, 32'({smp, trial}));
    conclude();
  end
endmodule // sac_top_tb
`default_nettype wire
